// File: core/hdirq_pkg.sv
package hdirq_pkg;
    // Register offsets
    localparam logic [7:0] HDIRQ_OFS_CTRL   = 8'h04;
    localparam logic [7:0] HDIRQ_OFS_STATUS = 8'h06;
    localparam logic [7:0] HDIRQ_OFS_MASK   = 8'h07;
    // Reset values
    localparam logic [7:0] HDIRQ_RST_CTRL   = 8'h00;
    localparam logic [7:0] HDIRQ_RST_STATUS = 8'h00;
    localparam logic [7:0] HDIRQ_RST_MASK   = 8'h00;
    // Mask register bits
    localparam int HDIRQ_MB_PIN_TRISTATE = 4;
    localparam int HDIRQ_MB_FAIL         = 3;
    localparam int HDIRQ_MB_MIC          = 1;
    localparam int HDIRQ_MB_THREE        = 0;
    // Status register bits share the mask positions of their events
    localparam int HDIRQ_SB_FAIL  = 3;
    localparam int HDIRQ_SB_MIC   = 1;
    localparam int HDIRQ_SB_THREE = 0;
    // Control register bits
    localparam int HDIRQ_CB_LAUNCH_DIS = 3;
    localparam int HDIRQ_CB_PIN_IRQ    = 2;
    // Writable bit sets and the set of status event bits
    localparam logic [7:0] HDIRQ_MASK_WMASK = 8'h1B;
    localparam logic [7:0] HDIRQ_CTRL_WMASK = 8'h0C;
    localparam logic [7:0] HDIRQ_STAT_EVENTS = 8'h0B;
    // Timing
    localparam int unsigned HDIRQ_CLK_KHZ      = 25000;
    localparam int unsigned HDIRQ_DELAY_MS     = 120;
    localparam int unsigned HDIRQ_PERIOD_MS    = 360;
    localparam int unsigned HDIRQ_DELAY_CYC    = HDIRQ_DELAY_MS * HDIRQ_CLK_KHZ;
    localparam int unsigned HDIRQ_PERIOD_CYC   = HDIRQ_PERIOD_MS * HDIRQ_CLK_KHZ;
    // Bus address
    localparam logic [6:0] HDIRQ_I2C_BASE = 7'h2A;  // Arbitrary value

    // Analog comparator results per jack band
    typedef struct packed {
        logic ring2_gnd;
        logic ring2_mic;
        logic sleeve_gnd;
        logic sleeve_mic;
    } hdirq_meas_t;

    // Switch closures
    typedef struct packed {
        logic mic_to_ring2;
        logic mic_to_sleeve;
        logic gnd_to_ring2;
        logic gnd_to_sleeve;
    } hdirq_sw_t;

    // Register write strobe
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } hdirq_wr_t;
endpackage : hdirq_pkg

// File: core/hdirq_top.sv
`timescale 1ns/1ps
module hdirq_top
    import hdirq_pkg::*;
#(
    parameter int unsigned DELAY_CYC  = hdirq_pkg::HDIRQ_DELAY_CYC,
    parameter int unsigned PERIOD_CYC = hdirq_pkg::HDIRQ_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Bus pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    input  wire logic                  addr_sel_i,
    // Jack side
    input  wire logic                  detect_launch_pin,
    input  wire hdirq_pkg::hdirq_meas_t meas_i,
    output hdirq_pkg::hdirq_sw_t       sw_o,
    // Microphone indicator, open drain
    output logic                       mic_detect_n_pin_o,
    output logic                       mic_detect_n_pin_oe
);
    import hdirq_pkg::*;

    // Refuse timing that the 24-bit sequencer counter cannot serve
    if (DELAY_CYC < 1 || PERIOD_CYC <= DELAY_CYC || PERIOD_CYC >= (1 << 24)) begin : g_bad_timing
        $error("hdirq_top: bad detection timing parameters");
    end

    typedef enum {I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA} hdirq_bus_t;
    typedef enum {D_IDLE, D_WAIT, D_HOLD} hdirq_det_t;

    logic [2:0]  scl_s_r, sda_s_r, launch_s_r;
    logic [1:0]  asel_s_r;
    hdirq_meas_t meas_m_r, meas_s_r;
    logic [7:0]  mask_r, ctrl_r, status_r, status_nxt;
    hdirq_wr_t   wr_r;
    logic        rd_stat_r;
    hdirq_bus_t  bus_r;
    logic [3:0]  bit_r;
    logic [7:0]  shift_r, tx_r, ptr_r;
    logic        rw_r, mack_r;
    hdirq_det_t  det_r;
    logic [23:0] cnt_r;
    logic [1:0]  class_r;
    logic        mic_detect_n_pin_r;
    logic [7:0]  ev_set;

    // Two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_s_r    <= 3'h7;
            sda_s_r    <= 3'h7;
            launch_s_r <= 3'h0;
            asel_s_r   <= 2'h0;
            meas_m_r   <= '0;
            meas_s_r   <= '0;
        end else begin
            scl_s_r    <= {scl_s_r[1:0], scl_i};
            sda_s_r    <= {sda_s_r[1:0], sda_i};
            launch_s_r <= {launch_s_r[1:0], detect_launch_pin};
            asel_s_r   <= {asel_s_r[0], addr_sel_i};
            meas_m_r   <= meas_i;
            meas_s_r   <= meas_m_r;
        end
    end

    wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
    wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
    wire sda_v    = sda_s_r[1];
    wire start_c  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
    wire stop_c   = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
    wire [6:0] my_addr = {HDIRQ_I2C_BASE[6:1], asel_s_r[1]};

    // Register read decode
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] st,
                                           input logic [7:0] cr, input logic [7:0] mk);
        unique case (a)
            HDIRQ_OFS_CTRL:   rd_byte = cr;
            HDIRQ_OFS_STATUS: rd_byte = st;
            HDIRQ_OFS_MASK:   rd_byte = mk;
            default:          rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // Byte that the pointer selects for the next read transfer
    wire [7:0] rd_sel = rd_byte(ptr_r, status_r, ctrl_r, mask_r);

    // Bus target: bits sampled on SCL rise, driven after SCL fall
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_r     <= I_IDLE;
            bit_r     <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            mack_r    <= 1'b0;
            sda_oe    <= 1'b0;
            wr_r      <= '0;
            rd_stat_r <= 1'b0;
        end else begin
            wr_r.stb  <= 1'b0;
            rd_stat_r <= 1'b0;
            if (start_c) begin
                bus_r  <= I_ADDR;
                bit_r  <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                bus_r  <= I_IDLE;
                sda_oe <= 1'b0;
            end else if (bus_r != I_IDLE && scl_rise) begin
                if (bit_r < 4'h8)
                    shift_r <= {shift_r[6:0], sda_v};
                if (bit_r == 4'h8)
                    mack_r <= ~sda_v;
                bit_r <= bit_r + 4'h1;
            end else if (bus_r != I_IDLE && scl_fall) begin
                if (bit_r == 4'h8) begin
                    sda_oe <= 1'b1;
                    unique case (bus_r)
                        I_ADDR: begin
                            rw_r <= shift_r[0];
                            if (shift_r[7:1] != my_addr) begin
                                bus_r  <= I_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end
                        I_REG:   ptr_r <= shift_r;
                        I_WDATA: begin
                            wr_r  <= '{stb: 1'b1, addr: ptr_r, data: shift_r};
                            ptr_r <= ptr_r + 8'h01;
                        end
                        I_RDATA: sda_oe <= 1'b0;
                        default: bus_r <= I_IDLE;
                    endcase
                end else if (bit_r == 4'h9) begin
                    bit_r  <= 4'h0;
                    sda_oe <= 1'b0;
                    if ((bus_r == I_ADDR && rw_r) || (bus_r == I_RDATA && mack_r)) begin
                        bus_r     <= I_RDATA;
                        tx_r      <= rd_sel;
                        sda_oe    <= ~rd_sel[7];
                        rd_stat_r <= (ptr_r == HDIRQ_OFS_STATUS);
                        ptr_r     <= ptr_r + 8'h01;
                    end else if (bus_r == I_RDATA) begin
                        bus_r <= I_IDLE;
                    end else if (bus_r == I_ADDR) begin
                        bus_r <= I_REG;
                    end else begin
                        bus_r <= I_WDATA;
                    end
                end else if (bus_r == I_RDATA) begin
                    sda_oe <= ~tx_r[3'(4'h7 - bit_r)];
                end
            end
        end
    end
    assign sda_o = 1'b0;

    // Mask register, bits 4, 3, 1, 0 writable
    always_ff @(posedge clk) begin
        if (!rstn)
            mask_r <= HDIRQ_RST_MASK;
        else if (wr_r.stb && wr_r.addr == HDIRQ_OFS_MASK)
            mask_r <= wr_r.data & HDIRQ_MASK_WMASK;
    end

    // Control register: launch disable and pin function
    always_ff @(posedge clk) begin
        if (!rstn)
            ctrl_r <= HDIRQ_RST_CTRL;
        else if (wr_r.stb && wr_r.addr == HDIRQ_OFS_CTRL)
            ctrl_r <= wr_r.data & HDIRQ_CTRL_WMASK;
    end

    wire launch_edge = launch_s_r[1] & ~launch_s_r[2];
    wire launch_ok   = launch_edge & ~ctrl_r[HDIRQ_CB_LAUNCH_DIS];
    wire delay_end   = (det_r == D_WAIT) && (cnt_r == 24'(DELAY_CYC - 1));
    wire period_end  = (det_r == D_HOLD) && (cnt_r == 24'(PERIOD_CYC - 1));

    // Detection sequencer; edges during a running sequence are ignored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            det_r <= D_IDLE;
            cnt_r <= 24'h000000;
        end else begin
            unique case (det_r)
                D_IDLE: begin
                    cnt_r <= 24'h000000;
                    if (launch_ok)
                        det_r <= D_WAIT;
                end
                D_WAIT: begin
                    cnt_r <= cnt_r + 24'h000001;
                    if (delay_end)
                        det_r <= D_HOLD;
                end
                D_HOLD: begin
                    cnt_r <= cnt_r + 24'h000001;
                    if (period_end)
                        det_r <= D_IDLE;
                end
            endcase
        end
    end

    // Impedance classification: 0 fail, 1 three-band, 2 standard, 3 swapped
    always_ff @(posedge clk) begin
        if (!rstn)
            class_r <= 2'h0;
        else if (delay_end) begin
            if (meas_s_r.ring2_gnd && meas_s_r.sleeve_gnd)
                class_r <= 2'h1;
            else if (meas_s_r.ring2_gnd && meas_s_r.sleeve_mic)
                class_r <= 2'h2;
            else if (meas_s_r.sleeve_gnd && meas_s_r.ring2_mic)
                class_r <= 2'h3;
            else
                class_r <= 2'h0;
        end
    end

    // Switch routing: open during a sequence, closed per result at its end
    always_ff @(posedge clk) begin
        if (!rstn)
            sw_o <= '0;
        else if (launch_ok && det_r == D_IDLE)
            sw_o <= '0;
        else if (period_end)
            sw_o <= '{mic_to_ring2:  class_r == 2'h3,
                      mic_to_sleeve: class_r == 2'h2,
                      gnd_to_ring2:  class_r == 2'h1 || class_r == 2'h2,
                      gnd_to_sleeve: class_r == 2'h1 || class_r == 2'h3};
    end

    // Event flags; a new event wins over a read clear
    always_comb begin
        ev_set = 8'h00;
        ev_set[HDIRQ_SB_FAIL]  = period_end && class_r == 2'h0;
        ev_set[HDIRQ_SB_MIC]   = period_end && class_r[1];
        ev_set[HDIRQ_SB_THREE] = period_end && class_r == 2'h1;
        status_nxt = (rd_stat_r ? 8'h00 : status_r) | ev_set;
    end

    always_ff @(posedge clk) begin
        if (!rstn)
            status_r <= HDIRQ_RST_STATUS;
        else
            status_r <= status_nxt & HDIRQ_STAT_EVENTS;
    end

    // Microphone presence as of the last finished sequence
    always_ff @(posedge clk) begin
        if (!rstn)
            mic_detect_n_pin_r <= 1'b0;
        else if (period_end)
            mic_detect_n_pin_r <= class_r[1];
    end

    // Unmasked pending events form the interrupt request
    wire irq_pend = (status_r[HDIRQ_SB_FAIL]  & ~mask_r[HDIRQ_MB_FAIL])
                  | (status_r[HDIRQ_SB_MIC]   & ~mask_r[HDIRQ_MB_MIC])
                  | (status_r[HDIRQ_SB_THREE] & ~mask_r[HDIRQ_MB_THREE]);

    // Indicator pin: only ever pulled low, or floated
    wire pin_low = ctrl_r[HDIRQ_CB_PIN_IRQ] ? irq_pend : mic_detect_n_pin_r;
    assign mic_detect_n_pin_o  = 1'b0;
    assign mic_detect_n_pin_oe = pin_low & ~mask_r[HDIRQ_MB_PIN_TRISTATE];
endmodule : hdirq_top

// File: dv/hdirq_top_asserts.sv
`timescale 1ns/1ps
module hdirq_top_asserts
    import hdirq_pkg::*;
#(
    parameter int unsigned DELAY_CYC  = 20,
    parameter int unsigned PERIOD_CYC = 60
) (
    // Clock, reset, bus
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic                   scl_i,
    input wire logic                   sda_i,
    input wire logic                   sda_o,
    input wire logic                   sda_oe,
    input wire logic                   addr_sel_i,
    // Jack and indicator
    input wire logic                   detect_launch_pin,
    input wire hdirq_pkg::hdirq_meas_t meas_i,
    input wire hdirq_pkg::hdirq_sw_t   sw_o,
    input wire logic                   mic_detect_n_pin_o,
    input wire logic                   mic_detect_n_pin_oe
);
    int unsigned zero_run_r;
    logic [3:0]  since_rise_r;
    logic        launch_q_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Length of the current run of open switches
    always_ff @(posedge clk) begin
        if (!rstn || sw_o != '0) zero_run_r <= 0;
        else zero_run_r <= zero_run_r + 1;
    end
    // Cycles since the launch pin last rose, saturating
    always_ff @(posedge clk) begin
        launch_q_r <= detect_launch_pin;
        if (!rstn) since_rise_r <= 4'hF;
        else if (detect_launch_pin && !launch_q_r) since_rise_r <= 4'h0;
        else if (since_rise_r != 4'hF) since_rise_r <= since_rise_r + 4'h1;
    end
    a_reset_outputs: assert property ($rose(rstn) |-> sw_o == '0 && !mic_detect_n_pin_oe && !sda_oe)
        else $error("outputs not quiet after reset");
    a_pins_open_drain: assert property (mic_detect_n_pin_o == 1'b0 && sda_o == 1'b0)
        else $error("open drain pin drives high");
    a_switch_class: assert property (sw_o inside {4'h0, 4'h3, 4'h6, 4'h9})
        else $error("illegal switch combination");
    a_switch_wait: assert property (sw_o != '0 && $past(sw_o) == '0 |-> zero_run_r >= PERIOD_CYC)
        else $error("switches closed too early");
    a_switch_clear_cause: assert property ($past(sw_o) != '0 && sw_o == '0 |-> since_rise_r <= 4'h8)
        else $error("switches opened without launch edge");
    a_switch_set_clear: assert property ($changed(sw_o) |-> sw_o == '0 || $past(sw_o) == '0)
        else $error("switches moved between routes directly");
    a_open_hold: assert property ((sw_o != '0) ##1 (sw_o == '0) |-> (sw_o == '0) [*8])
        else $error("switches reclosed during wait");
    a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
        else $error("data line moved while clock high");
endmodule : hdirq_top_asserts

bind hdirq_top hdirq_top_asserts #(.DELAY_CYC(DELAY_CYC), .PERIOD_CYC(PERIOD_CYC)) u_chk (
    .clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_sel_i(addr_sel_i), .detect_launch_pin(detect_launch_pin), .meas_i(meas_i),
    .sw_o(sw_o), .mic_detect_n_pin_o(mic_detect_n_pin_o),
    .mic_detect_n_pin_oe(mic_detect_n_pin_oe));

// File: dv/hdirq_host_model.sv
`timescale 1ns/1ps
module hdirq_host_model #(
    parameter int HP = 8
) (
    // Clock and wired data line
    input  wire logic clk,
    input  wire logic sda_line,
    // Driven bus pins
    output logic      scl,
    output logic      sda_low
);
    // Idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half();
        repeat (HP) @(posedge clk);
        #1;
    endtask : half
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop
    task automatic bit_io(input logic o, output logic b);
        sda_low = !o;
        half();
        scl = 1'b1;
        half();
        b = sda_line;
        scl = 1'b0;
    endtask : bit_io
    // Byte out, MSB first, then acknowledge bit; data in when d is all ones
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                           output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, b);
        ack = !b;
    endtask : byte_io
    task automatic write(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                         output logic ack);
        logic [7:0] q;
        logic       k1, k2, k3;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k1);
        byte_io(r, 1'b1, q, k2);
        byte_io(d, 1'b1, q, k3);
        stop();
        ack = k1 & k2 & k3;
    endtask : write
    task automatic read(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                        output logic ack);
        logic [7:0] q;
        logic       k1, k2, k3, k4;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k1);
        byte_io(r, 1'b1, q, k2);
        start();
        byte_io({a, 1'b1}, 1'b1, q, k3);
        byte_io(8'hFF, 1'b1, d, k4);
        stop();
        ack = k1 & k2 & k3;
    endtask : read
endmodule : hdirq_host_model

// File: dv/hdirq_top_tb_top.sv
`timescale 1ns/1ps
module hdirq_top_tb_top;
    import hdirq_pkg::*;
    localparam int unsigned DLY = 20;
    localparam int unsigned PER = 60;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        addr_sel_i = 1'b1;
    logic        detect_launch_pin = 1'b0;
    hdirq_meas_t meas_i = '0;
    hdirq_sw_t   sw_o;
    logic        sda_o, sda_oe, mic_o, mic_oe, scl, host_low, ack;
    logic [7:0]  rd;
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    wire         sda_line = !(host_low || (sda_oe && !sda_o));
    // Clock
    always #20 clk = ~clk;
    hdirq_top #(.DELAY_CYC(DLY), .PERIOD_CYC(PER)) dut (.clk(clk), .rstn(rstn), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel_i(addr_sel_i),
        .detect_launch_pin(detect_launch_pin), .meas_i(meas_i), .sw_o(sw_o),
        .mic_detect_n_pin_o(mic_o), .mic_detect_n_pin_oe(mic_oe));
    hdirq_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        u_host.write({HDIRQ_I2C_BASE[6:1], addr_sel_i}, r, d, ack);
        chk({7'h0, ack}, 8'h01);
    endtask : wr
    task automatic rdchk(input logic [7:0] r, input logic [7:0] e);
        u_host.read({HDIRQ_I2C_BASE[6:1], addr_sel_i}, r, rd, ack);
        chk(rd, e);
    endtask : rdchk
    // Plug event, then wait past the whole detection period
    task automatic launch(input hdirq_meas_t m);
        meas_i = m;
        detect_launch_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1 detect_launch_pin = 1'b1;
        repeat (DLY + PER + 12) @(posedge clk);
        #1;
    endtask : launch
    task automatic t_regs();
        rdchk(HDIRQ_OFS_MASK, 8'h00);
        rdchk(HDIRQ_OFS_STATUS, 8'h00);
        wr(HDIRQ_OFS_MASK, 8'hFF);
        rdchk(HDIRQ_OFS_MASK, 8'h1B);
        wr(HDIRQ_OFS_STATUS, 8'hFF);
        rdchk(HDIRQ_OFS_STATUS, 8'h00);
        rdchk(8'h01, 8'h00);
        u_host.write({HDIRQ_I2C_BASE[6:1], 1'b0}, HDIRQ_OFS_MASK, 8'h00, ack);
        chk({7'h0, ack}, 8'h00);
        rdchk(HDIRQ_OFS_MASK, 8'h1B);
        // Other address-select level: the device answers at the other address
        addr_sel_i = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        wr(HDIRQ_OFS_MASK, 8'h08);
        rdchk(HDIRQ_OFS_MASK, 8'h08);
        addr_sel_i = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        wr(HDIRQ_OFS_MASK, 8'h00);
        chk({7'h0, mic_oe}, 8'h00);
    endtask : t_regs
    task automatic t_classes();
        hdirq_meas_t m[4] = '{4'h9, 4'hA, 4'h6, 4'h0};
        logic [3:0]  s[4] = '{4'h6, 4'h3, 4'h9, 4'h0};
        logic [7:0]  st[4] = '{8'h02, 8'h01, 8'h02, 8'h08};
        for (int i = 0; i < 4; i++) begin
            launch(m[i]);
            chk({4'h0, sw_o}, {4'h0, s[i]});
            chk({7'h0, mic_oe}, {7'h0, st[i][1]});
            rdchk(HDIRQ_OFS_STATUS, st[i]);
        end
    endtask : t_classes
    task automatic t_irq();
        hdirq_meas_t m[4] = '{4'h0, 4'h9, 4'hA, 4'h6};
        logic [7:0]  mk[4] = '{8'h08, 8'h02, 8'h01, 8'h00};
        logic [7:0]  st[4] = '{8'h08, 8'h02, 8'h01, 8'h02};
        wr(HDIRQ_OFS_CTRL, 8'h04);
        for (int i = 0; i < 4; i++) begin
            wr(HDIRQ_OFS_MASK, mk[i]);
            launch(m[i]);
            chk({7'h0, mic_oe}, {7'h0, mk[i] == 8'h00});
            rdchk(HDIRQ_OFS_STATUS, st[i]);
            chk({7'h0, mic_oe}, 8'h00);
        end
    endtask : t_irq
    task automatic t_pin_float();
        wr(HDIRQ_OFS_CTRL, 8'h00);
        chk({7'h0, mic_oe}, 8'h01);
        wr(HDIRQ_OFS_MASK, 8'h10);
        chk({7'h0, mic_oe}, 8'h00);
        wr(HDIRQ_OFS_MASK, 8'h00);
        chk({7'h0, mic_oe}, 8'h01);
    endtask : t_pin_float
    task automatic t_launch_off();
        wr(HDIRQ_OFS_CTRL, 8'h08);
        launch(4'hA);
        chk({4'h0, sw_o}, 8'h09);
        rdchk(HDIRQ_OFS_STATUS, 8'h00);
        wr(HDIRQ_OFS_CTRL, 8'h00);
    endtask : t_launch_off
    // Second edge inside a running sequence must not restart it;
    // the plug is judged at the end of the wait, not before or after
    task automatic t_timing();
        int n = 0;
        meas_i = 4'h0;
        detect_launch_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1 detect_launch_pin = 1'b1;
        while (sw_o !== 4'h3 && n < 400) begin
            @(posedge clk);
            #1 n++;
            if (n == 10) meas_i = 4'hA;
            if (n == 30) begin
                detect_launch_pin = 1'b0;
                meas_i = 4'h9;
            end
            if (n == 34) detect_launch_pin = 1'b1;
        end
        chk(8'(n >= PER && n <= PER + 8), 8'h01);
    endtask : t_timing
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_regs();
        t_classes();
        t_irq();
        t_pin_float();
        t_launch_off();
        t_timing();
        give_verdict();
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end
endmodule : hdirq_top_tb_top
